// [rss_defs.vh]
`ifndef RSS_DEFS_VH
`define RSS_DEFS_VH
// Timing
`define RSS_CLK_HZ 10000000
`define RSS_WDT_MS 100
`define RSS_CYC_MIN_MS 1
`define RSS_CYC_MIN_CNT_MS 16'h0001
`define RSS_MS_CYCLES ((`RSS_CLK_HZ) / 1000)
// Phases
`define RSS_PH_STOP 4'h0
`define RSS_PH_CLR_IN 4'h1
`define RSS_PH_START 4'h2
`define RSS_PH_CLR_OUT 4'h3
`define RSS_PH_READ 4'h4
`define RSS_PH_MAIN 4'h5
`define RSS_PH_WRITE 4'h6
`define RSS_PH_EVENT 4'h7
// Stop causes
`define RSS_CAUSE_NONE 2'h0
`define RSS_CAUSE_WDT 2'h1
`define RSS_CAUSE_CYC 2'h2
`define RSS_CAUSE_CMD 2'h3
// Pulse channel positions and combined channel width
`define RSS_PULSE_LO 6
`define RSS_PULSE_HI 7
`define RSS_CIO_W 4
`endif

// [rss_ms_timer.v]
`include "rss_defs.vh"
module rss_ms_timer #(
  parameter CNT_W = 16,
  parameter MS_DIV = 10000
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Control
  input wire clear,
  input wire run,
  input wire [CNT_W-1:0] limit,
  // Status
  output reg expired,
  output wire ms_tick
);
  reg [23:0] div;
  reg [CNT_W-1:0] count;
  assign ms_tick = run && (div == MS_DIV - 1);
  always @(posedge clock) begin
    if (!nrst || clear || !run) begin
      div <= 24'h000000;
      count <= {CNT_W{1'b0}};
      expired <= 1'b0;
    end else begin
      if (ms_tick) begin
        div <= 24'h000000;
        if (count != limit)
          count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
        div <= div + 24'h000001;
      end
      if (ms_tick && count + {{(CNT_W-1){1'b0}}, 1'b1} >= limit)
        expired <= 1'b1;
    end
  end
endmodule

// [rss_supervisor.v]
`include "rss_defs.vh"
// Overview of operation
// - Fixed 100 ms watchdog stops controller
// - Cycle-time limit configurable, minimum 1 ms
// - Any supervision error ends in STOP
// - RUN to STOP asserts output command lock
// - RUN to STOP drives digital outputs low
// - RUN to STOP removes analog output supply
// - Remote inputs always read and presented
// - Restart clears inputs, then runs startup
// - Startup done releases lock, then cycles
// - Analog restart behaviour is preconfigurable
// - RUN cycle: read, main, write, repeat
// - Timer triggers operations at fixed interval; code counts u_wdt ms ticks, whose divider each wdt_retrigger resets
// - Timer or alarm preempts cyclic processing
// - Outputs 6 and 7 selectable as pulse
// - Relays: two groups of four, no indication
// - Relay unit has no diagnostics
// - Channel indicator lit while output active
// - Combined channel reads one while driven
module rss_supervisor #(
  parameter DO_W = 16,
  parameter DI_W = 16,
  parameter RI_W = 16,
  parameter CNT_W = 16,
  parameter MS_DIV = `RSS_MS_CYCLES,
  parameter [CNT_W-1:0] WDT_MS = `RSS_WDT_MS
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Operator control
  input wire run_request,
  input wire [CNT_W-1:0] cycle_limit_ms,
  input wire [CNT_W-1:0] timer_interval_ms,
  input wire analog_restart_on,
  input wire pulse_mode_lo,
  input wire pulse_mode_hi,
  // Firmware handshakes
  input wire wdt_retrigger,
  input wire startup_done,
  input wire main_done,
  input wire event_done,
  input wire alarm_pin,
  input wire pulse_lo,
  input wire pulse_hi,
  // Process image from firmware
  input wire [DO_W-1:0] output_process_image,
  // Field inputs
  input wire [DI_W-1:0] local_in_pin,
  input wire [RI_W-1:0] remote_in_pin,
  // State outputs
  output wire running,
  output reg [3:0] phase,
  output reg [1:0] stop_cause,
  output reg output_command_lock,
  output wire startup_routine,
  output wire main_cycle_routine,
  output wire event_routine,
  output reg timer_event,
  // Images and outputs
  output reg [DI_W-1:0] input_process_image,
  output reg [RI_W-1:0] remote_inputs,
  output reg [DO_W-1:0] local_out,
  output reg [DO_W-1:0] remote_out,
  output reg [DO_W-1:0] out_led,
  output reg analog_supply_on,
  output reg [7:0] relay_group_a,
  output reg [7:0] relay_group_b
);
  reg [DI_W-1:0] loc_s1, loc_s2;
  reg [RI_W-1:0] rem_s1, rem_s2;
  reg alarm_s1, alarm_s2, alarm_d;
  reg [3:0] resume_phase;
  reg [3:0] next_phase;
  reg [DO_W-1:0] out_image;
  reg [DO_W-1:0] drive;
  reg [CNT_W-1:0] tmr_cnt;
  reg [DI_W-1:0] readback;
  wire wdt_exp, cyc_exp, tick;
  wire in_run;
  wire [CNT_W-1:0] cyc_lim;
  wire alarm_rise;
  wire event_req;
  wire fault;
  integer i;
  assign in_run = (phase != `RSS_PH_STOP);
  assign running = in_run;
  assign startup_routine = (phase == `RSS_PH_START);
  assign main_cycle_routine = (phase == `RSS_PH_MAIN);
  assign event_routine = (phase == `RSS_PH_EVENT);
  assign alarm_rise = alarm_s2 && !alarm_d;
  assign cyc_lim = (cycle_limit_ms < `RSS_CYC_MIN_CNT_MS) ?
                   `RSS_CYC_MIN_CNT_MS : cycle_limit_ms;
  rss_ms_timer #(.CNT_W(CNT_W), .MS_DIV(MS_DIV)) u_wdt (
    .clock(clock),
    .nrst(nrst),
    .clear(wdt_retrigger),
    .run(in_run),
    .limit(WDT_MS),
    .expired(wdt_exp),
    .ms_tick(tick)
  );
  // Cycle monitor restarts each read phase
  rss_ms_timer #(.CNT_W(CNT_W), .MS_DIV(MS_DIV)) u_cyc (
    .clock(clock),
    .nrst(nrst),
    .clear(phase == `RSS_PH_READ || phase == `RSS_PH_CLR_OUT),
    .run(in_run && phase != `RSS_PH_START && phase != `RSS_PH_CLR_IN),
    .limit(cyc_lim),
    .expired(cyc_exp),
    .ms_tick()
  );
  assign fault = wdt_exp || cyc_exp;
  // Pin synchronisers
  always @(posedge clock) begin
    if (!nrst) begin
      loc_s1 <= {DI_W{1'b0}};
      loc_s2 <= {DI_W{1'b0}};
      rem_s1 <= {RI_W{1'b0}};
      rem_s2 <= {RI_W{1'b0}};
      alarm_s1 <= 1'b0;
      alarm_s2 <= 1'b0;
      alarm_d <= 1'b0;
    end else begin
      loc_s1 <= local_in_pin;
      loc_s2 <= loc_s1;
      rem_s1 <= remote_in_pin;
      rem_s2 <= rem_s1;
      alarm_s1 <= alarm_pin;
      alarm_s2 <= alarm_s1;
      alarm_d <= alarm_s2;
    end
  end
  // Remote inputs refreshed in every state
  always @(posedge clock) begin
    if (!nrst)
      remote_inputs <= {RI_W{1'b0}};
    else
      remote_inputs <= rem_s2;
  end
  always @(posedge clock) begin
    if (!nrst || !in_run || timer_interval_ms == {CNT_W{1'b0}}) begin
      tmr_cnt <= {CNT_W{1'b0}};
      timer_event <= 1'b0;
    end else begin
      if (tick && tmr_cnt + {{(CNT_W-1){1'b0}}, 1'b1} >= timer_interval_ms)
        tmr_cnt <= {CNT_W{1'b0}};
      else if (tick)
        tmr_cnt <= tmr_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      if (tick && tmr_cnt + {{(CNT_W-1){1'b0}}, 1'b1} >= timer_interval_ms)
        timer_event <= 1'b1;
      else if (phase == `RSS_PH_EVENT && event_done)
        timer_event <= 1'b0;
    end
  end
  assign event_req = timer_event || alarm_rise;
  // Phase sequencing
  always @* begin
    next_phase = phase;
    case (phase)
      `RSS_PH_STOP: begin
        if (run_request)
          next_phase = `RSS_PH_CLR_IN;
      end
      `RSS_PH_CLR_IN: next_phase = `RSS_PH_START;
      // Startup done leads to output clear
      `RSS_PH_START: begin
        if (startup_done)
          next_phase = `RSS_PH_CLR_OUT;
      end
      `RSS_PH_CLR_OUT: next_phase = `RSS_PH_READ;
      `RSS_PH_READ: next_phase = `RSS_PH_MAIN;
      `RSS_PH_MAIN: begin
        if (main_done)
          next_phase = `RSS_PH_WRITE;
      end
      `RSS_PH_WRITE: next_phase = `RSS_PH_READ;
      `RSS_PH_EVENT: begin
        if (event_done)
          next_phase = resume_phase;
      end
      default: next_phase = `RSS_PH_STOP;
    endcase
    if (event_req && (phase == `RSS_PH_READ || phase == `RSS_PH_MAIN ||
        phase == `RSS_PH_WRITE))
      next_phase = `RSS_PH_EVENT;
    if (in_run && (!run_request || fault))
      next_phase = `RSS_PH_STOP;
  end
  always @(posedge clock) begin
    if (!nrst) begin
      phase <= `RSS_PH_STOP;
      resume_phase <= `RSS_PH_READ;
      stop_cause <= `RSS_CAUSE_NONE;
    end else begin
      phase <= next_phase;
      if (next_phase == `RSS_PH_EVENT && phase != `RSS_PH_EVENT)
        resume_phase <= phase;
      if (in_run && next_phase == `RSS_PH_STOP)
        stop_cause <= wdt_exp ? `RSS_CAUSE_WDT :
                      cyc_exp ? `RSS_CAUSE_CYC : `RSS_CAUSE_CMD;
      else if (phase == `RSS_PH_CLR_IN)
        stop_cause <= `RSS_CAUSE_NONE;
    end
  end
  // Images, lock and analog supply
  always @(posedge clock) begin
    if (!nrst) begin
      input_process_image <= {DI_W{1'b0}};
      out_image <= {DO_W{1'b0}};
      output_command_lock <= 1'b1;
      analog_supply_on <= 1'b0;
    end else begin
      // Lock set on entry to STOP
      if (next_phase == `RSS_PH_STOP)
        output_command_lock <= 1'b1;
      else if (phase == `RSS_PH_START && startup_done)
        output_command_lock <= 1'b0;
      if (phase == `RSS_PH_CLR_IN)
        input_process_image <= {DI_W{1'b0}};
      else if (phase == `RSS_PH_READ)
        input_process_image <= loc_s2 | readback;
      if (next_phase == `RSS_PH_STOP || phase == `RSS_PH_CLR_OUT)
        out_image <= {DO_W{1'b0}};
      else if (phase == `RSS_PH_WRITE)
        out_image <= output_process_image;
      if (next_phase == `RSS_PH_STOP)
        analog_supply_on <= 1'b0;
      else if (phase == `RSS_PH_CLR_IN)
        analog_supply_on <= analog_restart_on;
      else if (phase == `RSS_PH_START && startup_done)
        analog_supply_on <= 1'b1;
    end
  end
  always @* begin
    drive = out_image;
    if (pulse_mode_lo)
      drive[`RSS_PULSE_LO] = pulse_lo;
    if (pulse_mode_hi)
      drive[`RSS_PULSE_HI] = pulse_hi;
    if (output_command_lock)
      drive = {DO_W{1'b0}};
  end
  always @(posedge clock) begin
    if (!nrst) begin
      local_out <= {DO_W{1'b0}};
      remote_out <= {DO_W{1'b0}};
      out_led <= {DO_W{1'b0}};
      relay_group_a <= 8'h00;
      relay_group_b <= 8'h00;
    end else begin
      local_out <= (next_phase == `RSS_PH_STOP) ? {DO_W{1'b0}} : drive;
      remote_out <= (next_phase == `RSS_PH_STOP) ? {DO_W{1'b0}} : drive;
      out_led <= (next_phase == `RSS_PH_STOP) ? {DO_W{1'b0}} : drive;
      relay_group_a <= (next_phase == `RSS_PH_STOP) ? 8'h00 :
                       {4'h0, drive[3:0]};
      relay_group_b <= (next_phase == `RSS_PH_STOP) ? 8'h00 :
                       {4'h0, drive[7:4]};
    end
  end
  always @* begin
    readback = {DI_W{1'b0}};
    for (i = 0; i < `RSS_CIO_W; i = i + 1) begin
      readback[i] = local_out[i];
    end
  end
endmodule

// [rss_checker.sv]
`include "rss_defs.vh"
module rss_checker (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Watched signals
  input wire run_request,
  input wire startup_done,
  input wire running,
  input wire [3:0] phase,
  input wire output_command_lock,
  input wire [15:0] input_process_image,
  input wire [15:0] local_out,
  input wire [15:0] remote_out,
  input wire [15:0] out_led,
  input wire [7:0] relay_group_a,
  input wire [7:0] relay_group_b,
  input wire analog_supply_on
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_lock_stop: assert property ($fell(running) |-> output_command_lock)
    else $error("lock not set at stop");
  a_outs_low: assert property (!running |->
    local_out == 16'h0000 && remote_out == 16'h0000) else $error("outputs on");
  a_analog_off: assert property ($fell(running) |-> !analog_supply_on)
    else $error("analog supply on at stop");
  a_clear_first: assert property ($rose(running) |->
    phase == `RSS_PH_CLR_IN ##1 input_process_image == 16'h0000)
    else $error("restart did not clear inputs");
  a_readback_set: assert property (phase == `RSS_PH_READ |=>
    (input_process_image[3:0] & $past(local_out[3:0])) ==
    $past(local_out[3:0])) else $error("combined channel readback low");
  a_lock_drop: assert property (
    phase == `RSS_PH_START && startup_done && run_request |=>
    phase == `RSS_PH_CLR_OUT && !output_command_lock)
    else $error("lock kept after startup");
  a_cycle_open: assert property (
    phase inside {`RSS_PH_READ, `RSS_PH_MAIN, `RSS_PH_WRITE} |->
    !output_command_lock) else $error("lock set while cycling");
  a_led_track: assert property (out_led == local_out)
    else $error("indicator differs from output");
  a_relay_map: assert property (
    relay_group_a[3:0] == local_out[3:0] && relay_group_b[3:0] == local_out[7:4])
    else $error("relay groups misplaced");
endmodule
bind rss_supervisor rss_checker u_chk (.clock, .nrst, .run_request,
  .startup_done, .running, .phase, .output_command_lock, .input_process_image,
  .local_out, .remote_out, .out_led, .relay_group_a, .relay_group_b,
  .analog_supply_on);

// [rss_fw_model.sv]
`include "rss_defs.vh"
module rss_fw_model (
  // Clock and knobs
  input wire clock,
  input wire [3:0] phase,
  input wire [7:0] main_wait,
  input wire retrig_en,
  // Handshakes
  output logic startup_done,
  output logic main_done,
  output logic event_done,
  output logic wdt_retrigger
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] last = 4'h0;
  logic [7:0] cnt = 8'h00;
  wire same = phase == last;
  initial {startup_done, main_done, event_done, wdt_retrigger} = 4'h0;
  // Handshakes a few cycles into START, MAIN and EVENT phases; retrigger throughout READ when enabled
  always @(negedge clock) begin
    last <= phase;
    cnt <= same ? cnt + 8'h01 : 8'h00;
    startup_done <= same && phase == `RSS_PH_START && cnt == 8'h02;
    main_done <= same && phase == `RSS_PH_MAIN && cnt == main_wait;
    event_done <= same && phase == `RSS_PH_EVENT && cnt == 8'h02;
    wdt_retrigger <= retrig_en && phase == `RSS_PH_READ;
  end
endmodule

// [rss_supervisor_tb.sv]
`include "rss_defs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module rss_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  int err_total = 0, n_compared = 0, cyc = 0, seed = 32'h2873;
  logic clock = 1'b0, nrst = 1'b0, run_request = 1'b0, alarm_pin = 1'b0;
  logic analog_restart_on = 1'b0, pulse_mode_lo = 1'b0, pulse_mode_hi = 1'b0;
  logic pulse_lo = 1'b0, pulse_hi = 1'b0, retrig_en = 1'b0;
  logic [7:0] main_wait = 8'h03;
  logic [15:0] cycle_limit_ms = 16'h000A, timer_interval_ms = 16'h0000;
  logic [15:0] output_process_image = 16'h0000, local_in_pin = 16'h0000;
  logic [15:0] remote_in_pin = 16'h0000, q[$];
  logic [3:0] prev_ph = 4'h0, mon_ph = 4'h0;
  logic [3:0] rb_hold = 4'h0, rb_exp = 4'h0;
  wire wdt_retrigger, startup_done, main_done, event_done, running;
  wire output_command_lock, analog_supply_on;
  wire [3:0] phase;
  wire [1:0] stop_cause;
  wire [15:0] input_process_image, remote_inputs, local_out, remote_out;
  always #50 clock = ~clock;
  rss_fw_model u_fw (.clock, .phase, .main_wait, .retrig_en, .startup_done,
    .main_done, .event_done, .wdt_retrigger);
  rss_supervisor #(.MS_DIV(4)) u_dut (.clock, .nrst, .run_request,
    .cycle_limit_ms, .timer_interval_ms, .analog_restart_on, .pulse_mode_lo,
    .pulse_mode_hi, .wdt_retrigger, .startup_done, .main_done, .event_done,
    .alarm_pin, .pulse_lo, .pulse_hi, .output_process_image, .local_in_pin,
    .remote_in_pin, .running, .phase, .stop_cause, .output_command_lock,
    .startup_routine(), .main_cycle_routine(), .event_routine(),
    .timer_event(), .input_process_image, .remote_inputs, .local_out,
    .remote_out, .out_led(), .analog_supply_on, .relay_group_a(),
    .relay_group_b());
  function automatic logic [15:0] exp_out(input logic [15:0] v);
    exp_out = v;
    if (pulse_mode_lo)
      exp_out[`RSS_PULSE_LO] = pulse_lo;
    if (pulse_mode_hi)
      exp_out[`RSS_PULSE_HI] = pulse_hi;
  endfunction
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_ph(input logic [3:0] p);
    for (int k = 0; k < 60 && phase !== p; k++)
      @(negedge clock);
  endtask
  task automatic run_case(input logic [15:0] lim, input logic [7:0] wt,
      input logic rt, input logic [1:0] cs, input logic [1:0] ev);
    cycle_limit_ms = lim;
    main_wait = wt;
    retrig_en = rt;
    local_in_pin = $random(seed);
    remote_in_pin = $random(seed);
    run_request = 1'b1;
    wait_ph(`RSS_PH_START);
    `CHK(analog_supply_on, analog_restart_on)
    for (int i = 0; i < 500 && running; i++)
      @(negedge clock);
    if (cs == `RSS_CAUSE_CMD) begin
      `CHK(running, 1'b1)
      `CHK(input_process_image, local_in_pin | {12'h000, rb_exp})
      `CHK(remote_inputs, remote_in_pin)
      if (ev != 2'h0) begin
        alarm_pin = ev[0];
        timer_interval_ms = ev[1] ? 16'h0002 : 16'h0000;
        wait_ph(`RSS_PH_EVENT);
        `CHK(phase, `RSS_PH_EVENT)
        alarm_pin = 1'b0;
        timer_interval_ms = 16'h0000;
        repeat (40) @(negedge clock);
      end
    end
    run_request = 1'b0;
    for (int i = 0; i < 10 && running; i++)
      @(negedge clock);
    `CHK(stop_cause, cs)
    `CHK(output_command_lock, 1'b1)
    `CHK(local_out, 16'h0000)
    remote_in_pin = $random(seed);
    repeat (4) @(negedge clock);
    `CHK(remote_inputs, remote_in_pin)
    $display("case done, cause %0d", cs);
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  // New output image at each cycle start
  always @(negedge clock) begin
    if (prev_ph == `RSS_PH_READ)
      rb_exp = rb_hold;
    if (phase == `RSS_PH_READ)
      rb_hold = local_out[3:0];
    if (!running)
      q.delete();
    else if (phase == `RSS_PH_READ &&
        prev_ph inside {`RSS_PH_CLR_OUT, `RSS_PH_WRITE}) begin
      output_process_image = $random(seed);
      q.push_back(exp_out(output_process_image));
    end
    prev_ph = phase;
  end
  // Outputs follow image one cycle after write
  always @(negedge clock) begin
    if (phase == `RSS_PH_WRITE && mon_ph == `RSS_PH_MAIN && q.size() > 0) begin
      repeat (2) @(posedge clock);
      @(negedge clock);
      if (running) begin
        `CHK(local_out, q[0])
        if (!pulse_mode_lo && !pulse_mode_hi)
          `CHK(remote_out, q[0])
      end
      if (q.size() > 0)
        q.pop_front();
    end
    mon_ph = phase;
  end
  initial begin
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    run_case(16'h000A, 8'h03, 1'b1, `RSS_CAUSE_CMD, 2'h0);
    pulse_mode_lo = 1'b1;
    pulse_mode_hi = 1'b1;
    pulse_lo = $random(seed);
    pulse_hi = ~pulse_lo;
    analog_restart_on = 1'b1;
    run_case(16'h000A, 8'h06, 1'b1, `RSS_CAUSE_CMD, 2'h1);
    pulse_mode_lo = 1'b0;
    pulse_mode_hi = 1'b0;
    analog_restart_on = 1'b0;
    run_case(16'h000A, 8'h03, 1'b1, `RSS_CAUSE_CMD, 2'h2);
    run_case(16'h00C8, 8'h03, 1'b0, `RSS_CAUSE_WDT, 2'h0);
    run_case(16'h0000, 8'h14, 1'b1, `RSS_CAUSE_CYC, 2'h0);
    report_and_stop();
  end
endmodule
